// >>> rtl/sac_pkg.sv
// Package with command codes, field layouts and event codes for the link command block
package sac_pkg;
    localparam logic [9:0] OCF_ADD_SYNC = 10'h007;
    localparam logic [9:0] OCF_ACCEPT = 10'h009;
    localparam logic [11:0] HANDLE_MAX = 12'hEFF;
    localparam logic [15:0] PKT_HV1 = 16'h0020;
    localparam logic [15:0] PKT_HV2 = 16'h0040;
    localparam logic [15:0] PKT_HV3 = 16'h0080;
    localparam logic [15:0] PKT_SYNC_MASK = 16'h00E0;
    localparam logic [7:0] ROLE_MASTER = 8'h00;
    localparam logic [7:0] ROLE_SLAVE = 8'h01;
    localparam logic [7:0] ST_SUCCESS = 8'h00;
    localparam logic [7:0] ST_BAD_PARAM = 8'h12;
    localparam logic [7:0] ST_NO_LINK = 8'h02;
    localparam logic [7:0] EVT_CONN_COMPLETE = 8'h03;
    localparam logic [7:0] EVT_CMD_STATUS = 8'h0F;
    localparam int MASK_BIT_CONN_COMPLETE = 2;
    localparam int MASK_BIT_CMD_STATUS = 14;
    typedef enum logic [1:0] {
        SAC_CMD_NONE,
        SAC_CMD_ADD,
        SAC_CMD_ACCEPT
    } sac_cmd_t;
endpackage : sac_pkg

// >>> rtl/sac_check_if.sv
// Interface between the decoder and the parameter checker
`timescale 1ns/10ps
interface sac_check_if;
    logic [15:0] handle;
    logic [15:0] pktMask;
    logic [7:0] role;
    logic isAdd;
    logic aclKnown;
    logic [7:0] status;
    logic [15:0] usableMask;
    logic [1:0] pktSel;
    modport core (output handle, pktMask, role, isAdd, aclKnown,
        input status, usableMask, pktSel);
    modport chk (input handle, pktMask, role, isAdd, aclKnown,
        output status, usableMask, pktSel);
endinterface : sac_check_if

// >>> rtl/sac_param_check.sv
// Parameter checker and packet type chooser
`timescale 1ns/10ps
module sac_param_check (
    sac_check_if.chk chk,
    input wire logic [15:0] supportedMask
);
    wire logic handleOk;
    wire logic maskOk;
    wire logic roleOk;
    wire logic [15:0] okMask;
    assign handleOk = (chk.handle[15:12] == 4'h0) && (chk.handle[11:0] <= sac_pkg::HANDLE_MAX);
    assign okMask = chk.pktMask & sac_pkg::PKT_SYNC_MASK & supportedMask;
    assign maskOk = (okMask != 16'h0000);
    assign roleOk = (chk.role == sac_pkg::ROLE_MASTER) || (chk.role == sac_pkg::ROLE_SLAVE);
    assign chk.usableMask = okMask;
    // Highest-quality enabled type preferred; any enabled one is legal
    assign chk.pktSel = okMask[7] ? 2'h3 : (okMask[6] ? 2'h2 : (okMask[5] ? 2'h1 : 2'h0));
    assign chk.status = chk.isAdd ?
        ((!handleOk || !maskOk) ? sac_pkg::ST_BAD_PARAM :
         (!chk.aclKnown ? sac_pkg::ST_NO_LINK : sac_pkg::ST_SUCCESS)) :
        (roleOk ? sac_pkg::ST_SUCCESS : sac_pkg::ST_BAD_PARAM);
endmodule : sac_param_check

// >>> rtl/sac_link_cmds.sv
// Command interpreter for add-synchronous and accept-connection link commands
// Operation
// - Add command code 0x0007 carries handle and two-byte packet type mask.
// - Synchronous link only on an existing ACL link named by handle.
// - Handle uses low 12 bits; 0x0F00 upward reserved.
// - Packet mask bits 0x0020 HV1, 0x0040 HV2, 0x0080 HV3; rest reserved.
// - Link manager sends only packet types enabled in the mask.
// - Link manager picks any enabled packet type.
// - Add command answered with a command status event.
// - Established synchronous link reported by connection complete with handle.
// - Neither command yields command complete; connection complete ends it.
// - Events masked by host event mask are suppressed.
// - Accept command code 0x0009 accepts a pending incoming request.
// - Accept carries six-byte peer address; link set up to it.
// - Role 0x00 switch and become master; 0x01 stay slave.
// - Role ignored when accepted request is synchronous; code still refuses a reserved role there.
// - Accept answered with command status when setup begins.
// - Accepted link reported by connection complete with handle.
`timescale 1ns/10ps
module sac_link_cmds (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic cmdValid,
    input wire logic [9:0] cmdOcf,
    input wire logic [15:0] cmdHandle,
    input wire logic [15:0] cmdPktMask,
    input wire logic [47:0] cmdAddr,
    input wire logic [7:0] cmdRole,
    output logic cmdReady,
    input wire logic [15:0] eventMask,
    input wire logic [15:0] supportedMask,
    input wire logic aclKnown,
    input wire logic reqPending,
    input wire logic reqIsSync,
    input wire logic [47:0] reqAddr,
    output logic lmStart,
    output logic lmIsAdd,
    output logic [11:0] lmHandle,
    output logic [47:0] lmAddr,
    output logic lmDoSwitch,
    output logic [15:0] lmPktMask,
    output logic [1:0] lmPktSel,
    input wire logic lmDone,
    input wire logic [7:0] lmStatus,
    input wire logic [11:0] lmNewHandle,
    output logic evtValid,
    output logic [7:0] evtCode,
    output logic [7:0] evtStatus,
    output logic [11:0] evtHandle,
    output logic [9:0] evtOcf,
    input wire logic evtReady,
    output logic busy
);
    typedef enum logic [2:0] {IDLE, STATUS, SETUP, COMPLETE} sac_state_t;
    sac_state_t state_q, state_d;
    sac_check_if chkBus();
    logic [15:0] handle_q;
    logic [15:0] pktMask_q;
    logic [7:0] role_q;
    logic [47:0] addr_q;
    logic isAdd_q;
    logic [7:0] status_q;
    logic [7:0] doneStatus_q;
    logic [11:0] doneHandle_q;
    logic [9:0] ocf_q;
    wire logic knownCmd;
    wire logic acceptOk;
    wire logic statusMasked;
    wire logic completeMasked;
    wire logic evtFire;
    wire logic [7:0] chkStatus;
    logic judge_q;
    wire logic statusDone;

    assign chkBus.handle = handle_q;
    assign chkBus.pktMask = pktMask_q;
    assign chkBus.role = role_q;
    assign chkBus.isAdd = isAdd_q;
    assign chkBus.aclKnown = aclKnown;
    // Accept without a matching pending request is refused as bad parameter
    assign acceptOk = reqPending && (reqAddr == addr_q);
    assign chkStatus = (!isAdd_q && !acceptOk) ? sac_pkg::ST_BAD_PARAM : chkBus.status;

    sac_param_check uChk (
        .chk(chkBus),
        .supportedMask(supportedMask)
    );

    assign knownCmd = (cmdOcf == sac_pkg::OCF_ADD_SYNC) || (cmdOcf == sac_pkg::OCF_ACCEPT);
    assign cmdReady = (state_q == IDLE);
    assign busy = (state_q != IDLE);
    assign statusMasked = !eventMask[sac_pkg::MASK_BIT_CMD_STATUS];
    assign completeMasked = !eventMask[sac_pkg::MASK_BIT_CONN_COMPLETE];
    // First status cycle hidden, the verdict is still being judged there
    assign evtValid = ((state_q == STATUS) && !judge_q && !statusMasked) ||
                      ((state_q == COMPLETE) && !completeMasked);
    assign evtFire = evtValid && evtReady;
    // A masked status must not leave on the stale verdict of the last command
    assign statusDone = (state_q == STATUS) && !judge_q && (evtFire || statusMasked);
    // Only status and connection complete codes exist here; no command complete path
    assign evtCode = (state_q == COMPLETE) ? sac_pkg::EVT_CONN_COMPLETE :
                     sac_pkg::EVT_CMD_STATUS;
    assign evtStatus = (state_q == COMPLETE) ? doneStatus_q : status_q;
    assign evtHandle = (state_q == COMPLETE) ? doneHandle_q : 12'h000;
    assign evtOcf = ocf_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            IDLE: begin
                if (cmdValid && knownCmd) begin
                    state_d = STATUS;
                end
            end
            STATUS: begin
                if (statusDone) begin
                    state_d = (status_q == sac_pkg::ST_SUCCESS) ? SETUP : IDLE;
                end
            end
            SETUP: begin
                if (lmDone) begin
                    state_d = COMPLETE;
                end
            end
            COMPLETE: begin
                if (evtFire || completeMasked) begin
                    state_d = IDLE;
                end
            end
            default: begin
                state_d = IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Parameters latched on acceptance so the host may change its bus afterwards
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            handle_q <= 16'h0000;
            pktMask_q <= 16'h0000;
            role_q <= 8'h00;
            addr_q <= 48'h000000000000;
            isAdd_q <= 1'b0;
            ocf_q <= 10'h000;
        end else if (state_q == IDLE && cmdValid && knownCmd) begin
            handle_q <= cmdHandle;
            pktMask_q <= cmdPktMask;
            role_q <= cmdRole;
            addr_q <= cmdAddr;
            isAdd_q <= (cmdOcf == sac_pkg::OCF_ADD_SYNC);
            ocf_q <= cmdOcf;
        end
    end

    // Status is judged one cycle after capture, from the latched fields
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            judge_q <= 1'b0;
        end else begin
            judge_q <= (state_q == IDLE) && cmdValid && knownCmd;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            status_q <= sac_pkg::ST_SUCCESS;
        end else if (judge_q) begin
            status_q <= chkStatus;
        end
    end

    // Link manager start pulse as status leaves with success
    wire logic startNow;
    assign startNow = statusDone && (status_q == sac_pkg::ST_SUCCESS);
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lmStart <= 1'b0;
            lmIsAdd <= 1'b0;
            lmHandle <= 12'h000;
            lmAddr <= 48'h000000000000;
            lmDoSwitch <= 1'b0;
            lmPktMask <= 16'h0000;
            lmPktSel <= 2'h0;
        end else begin
            lmStart <= startNow;
            if (startNow) begin
                lmIsAdd <= isAdd_q;
                lmHandle <= handle_q[11:0];
                lmAddr <= addr_q;
                // Role has no meaning for a synchronous accept
                lmDoSwitch <= !isAdd_q && !reqIsSync &&
                              (role_q == sac_pkg::ROLE_MASTER);
                lmPktMask <= chkBus.usableMask;
                lmPktSel <= chkBus.pktSel;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            doneStatus_q <= sac_pkg::ST_SUCCESS;
            doneHandle_q <= 12'h000;
        end else if (state_q == SETUP && lmDone) begin
            doneStatus_q <= lmStatus;
            // Handle only meaningful on success
            doneHandle_q <= (lmStatus == sac_pkg::ST_SUCCESS) ? lmNewHandle : 12'h000;
        end
    end

    sequence seqAccepted;
        (state_q == IDLE) && cmdValid && knownCmd;
    endsequence

    sequence seqStatusOut;
        (state_q == STATUS);
    endsequence

    sequence seqSetupDone;
        (state_q == SETUP) && lmDone;
    endsequence

    sequence seqJudgeAdd;
        judge_q && isAdd_q;
    endsequence

    sequence seqJudgeAccept;
        judge_q && !isAdd_q;
    endsequence

    AST_STATUS_AFTER_CMD: assert property (@(posedge core_clk) disable iff (!rstn)
        seqAccepted |=> seqStatusOut)
        else $error("command not followed by status state");

    AST_STATUS_CODE: assert property (@(posedge core_clk) disable iff (!rstn)
        (evtValid && state_q == STATUS) |-> evtCode == sac_pkg::EVT_CMD_STATUS)
        else $error("status event carries wrong code");

    AST_NO_CMD_COMPLETE: assert property (@(posedge core_clk) disable iff (!rstn)
        evtValid |-> (evtCode == sac_pkg::EVT_CMD_STATUS ||
                      evtCode == sac_pkg::EVT_CONN_COMPLETE))
        else $error("unexpected event code");

    AST_MASK_STATUS: assert property (@(posedge core_clk) disable iff (!rstn)
        (!eventMask[sac_pkg::MASK_BIT_CMD_STATUS] && state_q == STATUS) |-> !evtValid)
        else $error("masked status event emitted");

    AST_MASK_COMPLETE: assert property (@(posedge core_clk) disable iff (!rstn)
        (!eventMask[sac_pkg::MASK_BIT_CONN_COMPLETE] && state_q == COMPLETE) |-> !evtValid)
        else $error("masked complete event emitted");

    AST_PKT_SUBSET: assert property (@(posedge core_clk) disable iff (!rstn)
        lmStart |-> ((lmPktMask & ~(sac_pkg::PKT_SYNC_MASK & supportedMask)) == 16'h0000))
        else $error("link manager given reserved or unsupported packet types");

    AST_SYNC_NO_SWITCH: assert property (@(posedge core_clk) disable iff (!rstn)
        (startNow && reqIsSync && !isAdd_q) |=> !lmDoSwitch)
        else $error("role applied to synchronous accept");

    AST_ROLE_MASTER: assert property (@(posedge core_clk) disable iff (!rstn)
        (startNow && !isAdd_q && !reqIsSync && role_q == sac_pkg::ROLE_MASTER) |=> lmDoSwitch)
        else $error("master role did not request switch");

    AST_BAD_HANDLE: assert property (@(posedge core_clk) disable iff (!rstn)
        (seqJudgeAdd ##0 (handle_q[11:0] > sac_pkg::HANDLE_MAX)) |=>
        (status_q == sac_pkg::ST_BAD_PARAM))
        else $error("reserved handle not refused");

    AST_COMPLETE_HANDLE: assert property (@(posedge core_clk) disable iff (!rstn)
        (seqSetupDone ##0 (lmStatus == sac_pkg::ST_SUCCESS)) |=>
        (state_q == COMPLETE && evtHandle == $past(lmNewHandle)))
        else $error("complete event lacks new handle");

    AST_FAIL_NO_SETUP: assert property (@(posedge core_clk) disable iff (!rstn)
        (state_q == STATUS && status_q != sac_pkg::ST_SUCCESS) |-> !startNow)
        else $error("failed command started link manager");

    AST_STATUS_HIDDEN: assert property (@(posedge core_clk) disable iff (!rstn)
        judge_q |-> !evtValid)
        else $error("status shown before it was judged");

    AST_EVT_HOLD: assert property (@(posedge core_clk) disable iff (!rstn)
        (evtValid && !evtReady) |=>
        (!$stable(eventMask) || (evtValid && $stable(evtCode) && $stable(evtStatus))))
        else $error("event dropped or changed before it was taken");

    AST_LM_PULSE: assert property (@(posedge core_clk) disable iff (!rstn)
        lmStart |=> !lmStart)
        else $error("link manager start longer than one cycle");

    AST_NO_LINK: assert property (@(posedge core_clk) disable iff (!rstn)
        (seqJudgeAdd ##0 (!aclKnown && chkBus.status != sac_pkg::ST_BAD_PARAM)) |=>
        (status_q == sac_pkg::ST_NO_LINK))
        else $error("missing link not refused");

    AST_EMPTY_MASK: assert property (@(posedge core_clk) disable iff (!rstn)
        (seqJudgeAdd ##0 ((pktMask_q & sac_pkg::PKT_SYNC_MASK & supportedMask) == 16'h0000)) |=>
        (status_q == sac_pkg::ST_BAD_PARAM))
        else $error("empty packet mask not refused");

    AST_ROLE_RESERVED: assert property (@(posedge core_clk) disable iff (!rstn)
        (seqJudgeAccept ##0 (role_q > sac_pkg::ROLE_SLAVE)) |=>
        (status_q == sac_pkg::ST_BAD_PARAM))
        else $error("reserved role not refused");

    AST_ACCEPT_NO_REQ: assert property (@(posedge core_clk) disable iff (!rstn)
        (seqJudgeAccept ##0 !(reqPending && reqAddr == addr_q)) |=>
        (status_q == sac_pkg::ST_BAD_PARAM))
        else $error("accept without pending request not refused");

    AST_DONE_TO_COMPLETE: assert property (@(posedge core_clk) disable iff (!rstn)
        seqSetupDone |=> (state_q == COMPLETE))
        else $error("setup done not followed by complete state");
endmodule : sac_link_cmds

// >>> tb/sac_lm_model.sv
// Behavioural link manager that answers setup starts from the command block
`timescale 1ns/10ps
module sac_lm_model #(
    parameter logic [11:0] NEW_HANDLE = 12'h456
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic lmStart,
    input wire logic slow,
    input wire logic [7:0] failCode,
    output logic lmDone,
    output logic [7:0] lmStatus,
    output logic [11:0] lmNewHandle
);
    initial begin
        lmDone = 1'b0;
        lmStatus = 8'hFF;
        lmNewHandle = 12'h000;
    end
    // Answer after a short or a long link delay
    always @(posedge core_clk) begin
        if (rstn === 1'b1 && lmStart === 1'b1) begin
            repeat (slow ? 40 : 2) @(posedge core_clk);
            #1 lmDone = 1'b1;
            lmStatus = failCode;
            lmNewHandle = NEW_HANDLE;
            @(posedge core_clk);
            #1 lmDone = 1'b0;
            // Stale fields flip, so a late capture shows up
            lmStatus = ~failCode;
            lmNewHandle = ~NEW_HANDLE;
        end
    end
endmodule : sac_lm_model

// >>> tb/tb_sac_link_cmds.sv
// Self-checking bench for the link command interpreter
`timescale 1ns/10ps
`define CHK(a, e) begin totalChecks++; if ((a) !== (e)) begin errorCnt++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module tb_sac_link_cmds;
    localparam logic [11:0] NEWH = 12'h456;
    localparam logic [47:0] PEER = 48'hA1B2C3D4E5F6;
    logic core_clk = 0, rstn = 0, cmdValid = 0, aclKnown = 1, reqPending = 1, reqIsSync = 0;
    logic evtReady = 0, mSlow = 0, cmdReady, lmStart, lmIsAdd, lmDoSwitch, lmDone, evtValid, busy;
    logic [9:0] cmdOcf = 0;
    logic [9:0] evtOcf;
    logic [15:0] cmdHandle = 0, cmdPktMask = 0, eventMask = 16'hFFFF, supportedMask = 16'h00E0;
    logic [47:0] cmdAddr = 0, reqAddr = PEER;
    logic [47:0] lmAddr;
    logic [7:0] cmdRole = 0, mFail = 0;
    logic [7:0] lmStatus, evtCode, evtStatus;
    logic [11:0] lmHandle, lmNewHandle, evtHandle;
    logic [15:0] lmPktMask;
    logic [1:0] lmPktSel;
    int errorCnt = 0, totalChecks = 0;

    always #25 core_clk = ~core_clk;

    sac_link_cmds dut_u (.core_clk, .rstn, .cmdValid, .cmdOcf, .cmdHandle, .cmdPktMask,
        .cmdAddr, .cmdRole, .cmdReady, .eventMask, .supportedMask, .aclKnown, .reqPending,
        .reqIsSync, .reqAddr, .lmStart, .lmIsAdd, .lmHandle, .lmAddr, .lmDoSwitch, .lmPktMask,
        .lmPktSel, .lmDone, .lmStatus, .lmNewHandle, .evtValid, .evtCode, .evtStatus,
        .evtHandle, .evtOcf, .evtReady, .busy);

    sac_lm_model #(.NEW_HANDLE(NEWH)) lm_u (.core_clk, .rstn, .lmStart, .slow(mSlow),
        .failCode(mFail), .lmDone, .lmStatus, .lmNewHandle);

    // Any event seen must be one of the two kinds and enabled in the mask
    // Looked at mid-cycle, where the combinational valid has settled
    always @(negedge core_clk) begin
        if (evtValid === 1'b1) begin
            `CHK(evtCode == sac_pkg::EVT_CMD_STATUS ? eventMask[14] :
                evtCode == sac_pkg::EVT_CONN_COMPLETE && eventMask[2], 1'b1)
        end
    end

    task automatic tallyAndFinish();
        if (errorCnt == 0 && totalChecks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tallyAndFinish

    // Skips the first status cycle, where the status field is not yet final
    task automatic evt(input logic [7:0] code, input logic [7:0] st, input logic [9:0] ocf);
        int n;
        n = 0;
        @(posedge core_clk);
        #1;
        while (evtValid !== 1'b1 && n < 100) begin
            @(posedge core_clk);
            #1 n++;
        end
        `CHK(evtValid, 1'b1)
        `CHK(evtCode, code)
        `CHK(evtStatus, st)
        if (code == sac_pkg::EVT_CMD_STATUS) `CHK(evtOcf, ocf)
        else if (st == sac_pkg::ST_SUCCESS) `CHK(evtHandle, NEWH)
        evtReady = 1'b1;
        @(posedge core_clk);
        #1 evtReady = 1'b0;
    endtask : evt

    task automatic run(input logic [9:0] ocf, input logic [15:0] h, input logic [15:0] m,
            input logic [47:0] a, input logic [7:0] r, input logic [7:0] st,
            input logic [1:0] sel, input logic sw, input logic [15:0] ms);
        int n;
        n = 0;
        eventMask = ms;
        {cmdOcf, cmdHandle, cmdPktMask, cmdAddr, cmdRole, cmdValid} = {ocf, h, m, a, r, 1'b1};
        @(posedge core_clk);
        #1 cmdValid = 1'b0;
        if (ms[sac_pkg::MASK_BIT_CMD_STATUS]) evt(sac_pkg::EVT_CMD_STATUS, st, ocf);
        if (st == sac_pkg::ST_SUCCESS) begin
            while (lmStart !== 1'b1 && n < 50) begin
                @(posedge core_clk);
                #1 n++;
            end
            `CHK(lmStart, 1'b1)
            `CHK(busy, 1'b1)
            `CHK(lmIsAdd, ocf == sac_pkg::OCF_ADD_SYNC)
            if (ocf == sac_pkg::OCF_ADD_SYNC) begin
                `CHK(lmHandle, h[11:0])
                `CHK(lmPktMask, m & supportedMask & sac_pkg::PKT_SYNC_MASK)
                `CHK(lmPktSel, sel)
            end else begin
                `CHK(lmAddr, a)
                `CHK(lmDoSwitch, sw)
            end
            if (ms[sac_pkg::MASK_BIT_CONN_COMPLETE]) begin
                evt(sac_pkg::EVT_CONN_COMPLETE, mFail, ocf);
            end
        end
        n = 0;
        while (cmdReady !== 1'b1 && n < 100) begin
            @(posedge core_clk);
            #1 n++;
        end
        `CHK(cmdReady, 1'b1)
    endtask : run

    initial begin
        #(50 * 20000);
        errorCnt++;
        tallyAndFinish();
    end

    initial begin
        repeat (3) @(posedge core_clk);
        #1 rstn = 1'b1;
        run(sac_pkg::OCF_ADD_SYNC, 16'h0123, 16'h00A0, 0, 0, 8'h00, 2'd3, 0, 16'hFFFF);
        for (int i = 0; i < 3; i++) begin
            run(sac_pkg::OCF_ADD_SYNC, 16'h0010 + 16'(i), sac_pkg::PKT_HV1 << i, 0, 0, 8'h00,
                2'(i + 1), 0, 16'hFFFF);
        end
        run(sac_pkg::OCF_ADD_SYNC, 16'h0EFF, 16'h0040, 0, 0, 8'h00, 2'd2, 0, 16'hFFFF);
        run(sac_pkg::OCF_ADD_SYNC, 16'h0F00, 16'h0020, 0, 0, 8'h12, 0, 0, 16'hFFFF);
        run(sac_pkg::OCF_ADD_SYNC, 16'h0001, 16'hFF1F, 0, 0, 8'h12, 0, 0, 16'hFFFF);
        aclKnown = 1'b0;
        run(sac_pkg::OCF_ADD_SYNC, 16'h0005, 16'h0020, 0, 0, 8'h02, 0, 0, 16'hFFFF);
        aclKnown = 1'b1;
        for (int r = 0; r < 2; r++) begin
            run(sac_pkg::OCF_ACCEPT, 0, 0, PEER, 8'(r), 8'h00, 0, r == 0, 16'hFFFF);
        end
        reqIsSync = 1'b1;
        run(sac_pkg::OCF_ACCEPT, 0, 0, PEER, 8'h00, 8'h00, 0, 0, 16'hFFFF);
        run(sac_pkg::OCF_ACCEPT, 0, 0, PEER, 8'h02, 8'h12, 0, 0, 16'hFFFF);
        reqIsSync = 1'b0;
        run(sac_pkg::OCF_ACCEPT, 0, 0, PEER ^ 48'h1, 8'h01, 8'h12, 0, 0, 16'hFFFF);
        reqPending = 1'b0;
        run(sac_pkg::OCF_ACCEPT, 0, 0, PEER, 8'h01, 8'h12, 0, 0, 16'hFFFF);
        reqPending = 1'b1;
        // Slow link manager reporting a failed setup
        {mSlow, mFail} = {1'b1, 8'h04};
        run(sac_pkg::OCF_ADD_SYNC, 16'h0222, 16'h00E0, 0, 0, 8'h00, 2'd3, 0, 16'hFFFF);
        {mSlow, mFail} = {1'b0, 8'h00};
        run(sac_pkg::OCF_ADD_SYNC, 16'h0007, 16'h0060, 0, 0, 8'h00, 2'd2, 0, 16'h0000);
        run(sac_pkg::OCF_ACCEPT, 0, 0, PEER, 8'h01, 8'h00, 0, 0, 16'h4000);
        // Masked status after a success must still refuse on its own verdict
        run(sac_pkg::OCF_ADD_SYNC, 16'h0F10, 16'h0020, 0, 0, 8'h12, 0, 0, 16'h0004);
        run(sac_pkg::OCF_ACCEPT, 0, 0, PEER, 8'h00, 8'h00, 0, 1, 16'h0004);
        // Reset while the link manager works must leave the block idle
        eventMask = 16'h0000;
        {cmdOcf, cmdHandle, cmdPktMask, cmdValid} = {sac_pkg::OCF_ADD_SYNC, 16'h0030, 16'h0020, 1'b1};
        @(posedge core_clk);
        #1 cmdValid = 1'b0;
        repeat (3) @(posedge core_clk);
        #1 rstn = 1'b0;
        @(negedge core_clk);
        `CHK({cmdReady, busy, evtValid, lmStart}, 4'b1000)
        `CHK(lmPktMask, 16'h0000)
        @(posedge core_clk);
        #1 rstn = 1'b1;
        repeat (6) @(posedge core_clk);
        #1;
        eventMask = 16'hFFFF;
        {cmdOcf, cmdValid} = {10'h006, 1'b1};
        repeat (4) @(posedge core_clk);
        #1;
        `CHK(cmdReady, 1'b1)
        `CHK(evtValid, 1'b0)
        cmdValid = 1'b0;
        tallyAndFinish();
    end
endmodule : tb_sac_link_cmds
